/* File: pkg/lan_ctrl_pkg.sv */
// Constants for the network controller stop, heartbeat and bus-release block.
// Assumes a single 25 MHz clock and a plain register port.
package lan_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_MAIN = 3'h0;
  localparam logic [2:0] IDX_SECOND = 3'h1;
  localparam logic [2:0] IDX_THIRD = 3'h2;
  localparam logic [2:0] IDX_INT_STATUS = 3'h3;
  localparam logic [2:0] IDX_INT_MASK = 3'h4;
  localparam logic [2:0] IDX_CONFIG = 3'h5;

  // ----------------------------------------------------------------
  // Main control/status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_START = 1;
  localparam int BIT_STOP = 2;
  localparam int BIT_TX_ON = 4;
  localparam int BIT_RX_ON = 5;
  localparam int BIT_INTERRUPT_ENABLE_BIT = 6;
  localparam int BIT_INTR = 7;
  localparam int BIT_COL_ERR = 13;
  localparam int BIT_ERR = 15;

  // Interrupt status bit positions
  localparam int INT_HEARTBEAT = 0;
  localparam int INT_DMA_DONE = 1;
  localparam int INT_STOPPED = 2;
  localparam int INT_BITS = 3;

  // Config bit position
  localparam int BIT_ALE_POL = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [2:0] RST_INT = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int HB_WINDOW_NS = 4000;
  localparam int HB_CYCLES = HB_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [7:0] HB_LAST = 8'(HB_CYCLES - 1);

endpackage

/* File: logic/lan_ctrl_stop_heartbeat.sv */
// Control/status, heartbeat check, stop handling and DMA bus release logic.
// Assumes one clock domain; collision and hold acknowledge arrive from pins.
//
// Behaviour
// - Collision seen from transmit start to window end means heartbeat good.
// - Heartbeat window after each transmission lasts 4 microseconds.
// - Address latch polarity 0: strobe may stay high at mastership end.
// - Address latch polarity 1: strobe never driven low at mastership end.
// - Stop write is latched; internal reset follows once slave access ends.
// - Second and third control registers survive stop.
// - Main register read returns a latched, stable copy.
// - Interrupt enable bit can be set regardless of stop.
// - Writing stop while stopped leaves other main bits unchanged.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps

module lan_ctrl_stop_heartbeat
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_tx_busy,
  input wire logic i_collision,
  input wire logic i_dma_req,
  input wire logic i_hold_ack,
  output logic o_tx_en,
  output logic o_rx_en,
  output logic o_hold_req,
  output logic o_ale,
  output logic o_ale_oe,
  output logic [15:0] o_dal,
  output logic o_dal_oe,
  output logic o_dma_busy,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // DMA state machine encoding
  // ----------------------------------------------------------------
  typedef enum logic [4:0]
  {
    DMA_IDLE = 5'b00001,
    DMA_REQ = 5'b00010,
    DMA_ADDR = 5'b00100,
    DMA_DATA = 5'b01000,
    DMA_REL = 5'b10000
  } dma_state_e;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic col_meta_ff;
  logic col_sync_ff;
  logic ack_meta_ff;
  logic ack_sync_ff;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      col_meta_ff <= 1'b0;
      col_sync_ff <= 1'b0;
      ack_meta_ff <= 1'b0;
      ack_sync_ff <= 1'b0;
    end
    else
    begin
      col_meta_ff <= i_collision;
      col_sync_ff <= col_meta_ff;
      ack_meta_ff <= i_hold_ack;
      ack_sync_ff <= ack_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register, heartbeat and DMA state
  // ----------------------------------------------------------------
  logic start_ff;
  logic stop_ff;
  logic run_ff;
  logic interrupt_enable_bit_ff;
  logic col_err_ff;
  logic stop_pend_ff;
  logic [15:0] second_ff;
  logic [15:0] third_ff;
  logic [lan_ctrl_pkg::INT_BITS-1:0] int_status_ff;
  logic [lan_ctrl_pkg::INT_BITS-1:0] int_mask_ff;
  logic ale_pol_ff;
  logic [15:0] rdata_ff;
  logic irq_ff;
  logic tx_prev_ff;
  logic hb_open_ff;
  logic hb_seen_ff;
  logic [7:0] hb_cnt_ff;
  dma_state_e dma_state_ff;
  dma_state_e nxt_dma_state;
  logic hold_req_ff;
  logic ale_ff;
  logic ale_oe_ff;
  logic [15:0] dal_ff;
  logic dal_oe_ff;
  logic dma_busy_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_main = i_wr && (i_addr == lan_ctrl_pkg::IDX_MAIN);
  wire wr_second = i_wr && (i_addr == lan_ctrl_pkg::IDX_SECOND);
  wire wr_third = i_wr && (i_addr == lan_ctrl_pkg::IDX_THIRD);
  wire wr_int_status = i_wr && (i_addr == lan_ctrl_pkg::IDX_INT_STATUS);
  wire wr_int_mask = i_wr && (i_addr == lan_ctrl_pkg::IDX_INT_MASK);
  wire wr_config = i_wr && (i_addr == lan_ctrl_pkg::IDX_CONFIG);
  wire w_stop = i_wdata[lan_ctrl_pkg::BIT_STOP];
  wire w_start = i_wdata[lan_ctrl_pkg::BIT_START];
  wire w_interrupt_enable_bit = i_wdata[lan_ctrl_pkg::BIT_INTERRUPT_ENABLE_BIT];
  wire w_col_clr = i_wdata[lan_ctrl_pkg::BIT_COL_ERR];
  // Main writes are refused during the one cycle the stop is being applied
  wire main_take = wr_main && !stop_pend_ff;
  wire stop_repeat = main_take && w_stop && stop_ff;
  wire stop_new = main_take && w_stop && !stop_ff;
  wire start_cmd = main_take && !w_stop && w_start && !start_ff;

  // ----------------------------------------------------------------
  // Heartbeat check
  // ----------------------------------------------------------------
  wire tx_fall = tx_prev_ff && !i_tx_busy;
  wire tx_rise = !tx_prev_ff && i_tx_busy;
  wire hb_end = hb_open_ff && (hb_cnt_ff == lan_ctrl_pkg::HB_LAST);
  // Collision anywhere from transmit start to window end counts as heartbeat
  wire hb_fail = hb_end && !hb_seen_ff && !col_sync_ff;
  wire hb_tracking = i_tx_busy || hb_open_ff;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || stop_pend_ff)
    begin
      tx_prev_ff <= 1'b0;
      hb_open_ff <= 1'b0;
      hb_seen_ff <= 1'b0;
      hb_cnt_ff <= 8'h00;
    end
    else
    begin
      tx_prev_ff <= i_tx_busy;
      if (tx_rise)
        hb_seen_ff <= col_sync_ff;
      else if (hb_tracking && col_sync_ff)
        hb_seen_ff <= 1'b1;
      if (tx_fall)
      begin
        hb_open_ff <= 1'b1;
        hb_cnt_ff <= 8'h00;
      end
      else if (hb_end)
        hb_open_ff <= 1'b0;
      else if (hb_open_ff)
        hb_cnt_ff <= hb_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Main control/status register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      start_ff <= 1'b0;
      stop_ff <= 1'b1;
      run_ff <= 1'b0;
      interrupt_enable_bit_ff <= 1'b0;
      col_err_ff <= 1'b0;
      stop_pend_ff <= 1'b0;
    end
    else if (stop_pend_ff)
    begin
      // Internal reset one cycle after the slave write has completed
      stop_pend_ff <= 1'b0;
      stop_ff <= 1'b1;
      start_ff <= 1'b0;
      run_ff <= 1'b0;
      interrupt_enable_bit_ff <= 1'b0;
      col_err_ff <= 1'b0;
    end
    else
    begin
      stop_pend_ff <= stop_new;
      if (start_cmd)
      begin
        start_ff <= 1'b1;
        stop_ff <= 1'b0;
        run_ff <= 1'b1;
      end
      // Repeated stop write touches nothing else
      if (main_take && !stop_repeat)
        interrupt_enable_bit_ff <= w_interrupt_enable_bit;
      if (hb_fail)
        col_err_ff <= 1'b1;
      else if (main_take && !stop_repeat && w_col_clr)
        col_err_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Other registers
  // ----------------------------------------------------------------
  // Second and third registers have no reset path from stop
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      second_ff <= lan_ctrl_pkg::RST_CTRL;
      third_ff <= lan_ctrl_pkg::RST_CTRL;
      int_mask_ff <= lan_ctrl_pkg::RST_INT;
      ale_pol_ff <= 1'b0;
    end
    else
    begin
      if (wr_second)
        second_ff <= i_wdata;
      if (wr_third)
        third_ff <= i_wdata;
      if (wr_int_mask)
        int_mask_ff <= i_wdata[lan_ctrl_pkg::INT_BITS-1:0];
      if (wr_config)
        ale_pol_ff <= i_wdata[lan_ctrl_pkg::BIT_ALE_POL];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire dma_done = (dma_state_ff == DMA_REL);
  wire [lan_ctrl_pkg::INT_BITS-1:0] int_set = {stop_pend_ff, dma_done, hb_fail};
  wire [lan_ctrl_pkg::INT_BITS-1:0] int_clr =
    wr_int_status ? i_wdata[lan_ctrl_pkg::INT_BITS-1:0] : lan_ctrl_pkg::RST_INT;
  // Set wins over a simultaneous write-one clear
  wire [lan_ctrl_pkg::INT_BITS-1:0] nxt_int_status = (int_status_ff & ~int_clr) | int_set;
  wire irq_pending = |(nxt_int_status & int_mask_ff);

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      int_status_ff <= lan_ctrl_pkg::RST_INT;
      irq_ff <= 1'b0;
    end
    else
    begin
      int_status_ff <= nxt_int_status;
      irq_ff <= irq_pending;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [15:0] main_value = {
    col_err_ff,
    1'b0,
    col_err_ff,
    5'h00,
    |(int_status_ff & int_mask_ff),
    interrupt_enable_bit_ff,
    run_ff,
    run_ff,
    1'b0,
    stop_ff,
    start_ff,
    1'b0
  };
  wire [15:0] rd_mux =
    (i_addr == lan_ctrl_pkg::IDX_MAIN) ? main_value :
    (i_addr == lan_ctrl_pkg::IDX_SECOND) ? second_ff :
    (i_addr == lan_ctrl_pkg::IDX_THIRD) ? third_ff :
    (i_addr == lan_ctrl_pkg::IDX_INT_STATUS) ? {13'h0000, int_status_ff} :
    (i_addr == lan_ctrl_pkg::IDX_INT_MASK) ? {13'h0000, int_mask_ff} :
    (i_addr == lan_ctrl_pkg::IDX_CONFIG) ? {15'h0000, ale_pol_ff} :
    16'h0000;

  // Snapshot at the strobe so the value cannot move during the cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      rdata_ff <= 16'h0000;
    else if (i_rd)
      rdata_ff <= rd_mux;
    else
      rdata_ff <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // DMA bus master
  // ----------------------------------------------------------------
  // Asserted latch level follows polarity: 0 active high, 1 active low
  wire ale_active = ~ale_pol_ff;

  always_comb
  begin
    nxt_dma_state = dma_state_ff;
    case (dma_state_ff)
      DMA_IDLE:
        if (run_ff && i_dma_req)
          nxt_dma_state = DMA_REQ;
      DMA_REQ:
        if (ack_sync_ff)
          nxt_dma_state = DMA_ADDR;
      DMA_ADDR:
        nxt_dma_state = DMA_DATA;
      DMA_DATA:
        nxt_dma_state = DMA_REL;
      DMA_REL:
        nxt_dma_state = DMA_IDLE;
      default:
        nxt_dma_state = DMA_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || stop_pend_ff)
    begin
      // Stop drops the request and floats every bus pin at once
      dma_state_ff <= DMA_IDLE;
      hold_req_ff <= 1'b0;
      ale_ff <= 1'b1;
      ale_oe_ff <= 1'b0;
      dal_ff <= 16'h0000;
      dal_oe_ff <= 1'b0;
      dma_busy_ff <= 1'b0;
    end
    else
    begin
      dma_state_ff <= nxt_dma_state;
      hold_req_ff <= (nxt_dma_state != DMA_IDLE) && (nxt_dma_state != DMA_REL);
      dma_busy_ff <= (nxt_dma_state != DMA_IDLE);
      dal_oe_ff <= (nxt_dma_state == DMA_ADDR) || (nxt_dma_state == DMA_DATA);
      dal_ff <= (nxt_dma_state == DMA_ADDR) ? second_ff : third_ff;
      ale_oe_ff <= (nxt_dma_state == DMA_ADDR) || (nxt_dma_state == DMA_DATA) ||
                   (nxt_dma_state == DMA_REL);
      if (nxt_dma_state == DMA_ADDR)
        ale_ff <= ale_active;
      else if (nxt_dma_state == DMA_DATA)
        ale_ff <= ~ale_active;
      else
        ale_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata = rdata_ff;
  assign o_tx_en = run_ff;
  assign o_rx_en = run_ff;
  assign o_hold_req = hold_req_ff;
  assign o_ale = ale_ff;
  assign o_ale_oe = ale_oe_ff;
  assign o_dal = dal_ff;
  assign o_dal_oe = dal_oe_ff;
  assign o_dma_busy = dma_busy_ff;
  assign o_irq = irq_ff;

endmodule // lan_ctrl_stop_heartbeat

/* File: verification/lan_ctrl_sva.sv */
// Checker for the stop, heartbeat and bus-release block.
// Sees only the top module ports; bound at the foot of this file.
`timescale 1ns/100ps
module lan_ctrl_chk
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_tx_en,
  input wire logic o_rx_en,
  input wire logic o_hold_req,
  input wire logic o_ale,
  input wire logic o_ale_oe,
  input wire logic o_dal_oe,
  input wire logic o_dma_busy
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  reg_keep_a: assert property (i_wr && i_addr == 3'h1 ##1 i_rd && i_addr == 3'h1
    |=> o_rdata == $past(i_wdata, 2)) else $error("second register lost");
  stop_halt_a: assert property (i_wr && i_addr == lan_ctrl_pkg::IDX_MAIN
    && i_wdata[lan_ctrl_pkg::BIT_STOP] |-> ##2 !o_tx_en && !o_rx_en && !o_hold_req
    && !o_dma_busy) else $error("stop did not halt");
  hold_busy_a: assert property (o_hold_req |-> o_dma_busy)
    else $error("bus held while idle");
  dal_owner_a: assert property (o_dal_oe |-> o_hold_req)
    else $error("lines driven without mastership");
  dal_phase_a: assert property ($rose(o_dal_oe) |-> o_ale_oe ##1 o_dal_oe ##1 !o_dal_oe)
    else $error("address and data phases wrong");
  ale_end_a: assert property ($fell(o_hold_req) |-> o_ale)
    else $error("strobe low at mastership end");
  ale_release_a: assert property ($fell(o_hold_req) |=> !o_ale_oe && o_ale)
    else $error("strobe not released");
endmodule // lan_ctrl_chk

bind lan_ctrl_stop_heartbeat lan_ctrl_chk chk (.i_clk, .i_nrst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_tx_en, .o_rx_en, .o_hold_req, .o_ale, .o_ale_oe,
  .o_dal_oe, .o_dma_busy);

/* File: verification/bus_grant_model.sv */
// Bus arbiter standing in for the host side of the shared local bus.
// Grants after a short or long wait; drops grant once request falls.
`timescale 1ns/100ps
module bus_grant_model
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_hold_req,
  input wire logic i_slow,
  output logic o_hold_ack
);
  logic [3:0] wait_ff;
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || !i_hold_req)
    begin
      wait_ff <= 4'h0;
      o_hold_ack <= 1'b0;
    end
    else if (wait_ff == (i_slow ? 4'h6 : 4'h1))
      o_hold_ack <= 1'b1;
    else
      wait_ff <= wait_ff + 4'h1;
  end
endmodule // bus_grant_model

/* File: verification/lan_ctrl_stop_heartbeat_bus_rules_tb_top.sv */
// Testbench for the stop, heartbeat and bus-release block.
// Bench acts as host on the register port; arbiter model grants the bus.
`timescale 1ns/100ps
module lan_ctrl_stop_heartbeat_bus_rules_tb_top;
  logic i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_tx_busy = 0;
  logic i_collision = 0, i_dma_req = 0, slow = 0, i_hold_ack;
  logic [2:0] i_addr = 0;
  logic [15:0] i_wdata = 0, o_rdata, o_dal;
  logic o_tx_en, o_rx_en, o_hold_req, o_ale, o_ale_oe, o_dal_oe, o_dma_busy, o_irq;
  int n_errors = 0, checks_done = 0;
  always #20 i_clk = ~i_clk;
  lan_ctrl_stop_heartbeat dut (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_tx_busy, .i_collision, .i_dma_req, .i_hold_ack, .o_tx_en, .o_rx_en,
    .o_hold_req, .o_ale, .o_ale_oe, .o_dal, .o_dal_oe, .o_dma_busy, .o_irq);
  bus_grant_model arb (.i_clk, .i_nrst, .i_hold_req(o_hold_req), .i_slow(slow),
    .o_hold_ack(i_hold_ack));
  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    // Strobe may still be high from a previous write: let it drop first
    if (i_wr)
      @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata & m, e);
    @(posedge i_clk);
  endtask
  task automatic hb(input int col_at, input logic fail);
    i_tx_busy <= 1'b1;
    i_collision <= (col_at < 0);
    repeat (5) @(posedge i_clk);
    i_tx_busy <= 1'b0;
    for (int k = 0; k < 130; k++)
    begin
      i_collision <= (k == col_at);
      @(posedge i_clk);
    end
    rd(lan_ctrl_pkg::IDX_MAIN, 16'h2000, {2'h0, fail, 13'h0});
    rd(lan_ctrl_pkg::IDX_INT_STATUS, 16'h0001, {15'h0, fail});
  endtask
  task automatic dma(input logic pol);
    int n;
    n = 0;
    // Clear sticky status so each transfer must set its own done bit
    wr(lan_ctrl_pkg::IDX_INT_STATUS, 16'h0007);
    wr(lan_ctrl_pkg::IDX_CONFIG, {15'h0, pol});
    slow <= pol;
    i_dma_req <= 1'b1;
    while (o_hold_req !== 1'b1 && n++ < 50)
      @(negedge i_clk);
    @(posedge i_clk);
    i_dma_req <= 1'b0;
    while (o_dal_oe !== 1'b1 && n++ < 60)
      @(negedge i_clk);
    chk(o_dal, 16'h1234);
    chk(16'(o_ale), {15'h0, ~pol});
    @(negedge i_clk);
    chk(o_dal, 16'h5678);
    @(negedge i_clk);
    chk(16'(o_ale), 16'h0001);
    chk(16'(o_hold_req), 16'h0000);
    @(posedge i_clk);
    rd(lan_ctrl_pkg::IDX_INT_STATUS, 16'h0002, 16'h0002);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial
  begin
    // No receive buffer is ever handed over, so none of zero length
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(lan_ctrl_pkg::IDX_MAIN, 16'hffff, 16'h0004);
    rd(3'h6, 16'hffff, 16'h0000);
    wr(lan_ctrl_pkg::IDX_SECOND, 16'h1234);
    rd(lan_ctrl_pkg::IDX_SECOND, 16'hffff, 16'h1234);
    wr(lan_ctrl_pkg::IDX_THIRD, 16'h5678);
    wr(lan_ctrl_pkg::IDX_MAIN, 16'h0002);
    wr(lan_ctrl_pkg::IDX_INT_MASK, 16'h0001);
    $display("Test registers done");
    hb(-1, 1'b0);
    hb(90, 1'b0);
    hb(110, 1'b1);
    @(negedge i_clk);
    chk(16'(o_irq), 16'h0001);
    @(posedge i_clk);
    wr(lan_ctrl_pkg::IDX_INT_MASK, 16'h0000);
    repeat (2) @(negedge i_clk);
    chk(16'(o_irq), 16'h0000);
    @(posedge i_clk);
    wr(lan_ctrl_pkg::IDX_INT_STATUS, 16'h0007);
    wr(lan_ctrl_pkg::IDX_MAIN, 16'h2002);
    hb(999, 1'b1);
    wr(lan_ctrl_pkg::IDX_INT_STATUS, 16'h0007);
    wr(lan_ctrl_pkg::IDX_MAIN, 16'h2002);
    $display("Test heartbeat done");
    dma(1'b0);
    dma(1'b1);
    $display("Test bus release done");
    wr(lan_ctrl_pkg::IDX_MAIN, 16'h0004);
    @(negedge i_clk);
    chk(16'(o_tx_en), 16'h0001);
    @(negedge i_clk);
    chk(16'(o_tx_en), 16'h0000);
    @(posedge i_clk);
    rd(lan_ctrl_pkg::IDX_MAIN, 16'hffff, 16'h0004);
    rd(lan_ctrl_pkg::IDX_THIRD, 16'hffff, 16'h5678);
    rd(lan_ctrl_pkg::IDX_INT_STATUS, 16'h0004, 16'h0004);
    wr(lan_ctrl_pkg::IDX_MAIN, 16'h0040);
    rd(lan_ctrl_pkg::IDX_MAIN, 16'hffff, 16'h0044);
    wr(lan_ctrl_pkg::IDX_MAIN, 16'h0004);
    rd(lan_ctrl_pkg::IDX_MAIN, 16'hffff, 16'h0044);
    rd(lan_ctrl_pkg::IDX_SECOND, 16'hffff, 16'h1234);
    $display("Test stop done");
    report_and_stop();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    report_and_stop();
  end
endmodule // lan_ctrl_stop_heartbeat_bus_rules_tb_top
